//--- hw/bus_matrix_pkg.sv
// Shared constants and types for the bus matrix decode and arbitration logic
package bus_matrix_pkg;
    localparam int NUM_MST = 5;
    localparam int NUM_SLV = 5;
    localparam int ADDR_W  = 32;
    localparam int EXT_CS_W = 8;

    typedef logic [2:0] mst_idx_type;
    typedef logic [2:0] slv_idx_type;

    localparam mst_idx_type MST_INSTR        = 3'h0;
    localparam mst_idx_type MST_DATA         = 3'h1;
    localparam mst_idx_type MST_PERIPH_DMA   = 3'h2;
    localparam mst_idx_type MST_DISPLAY      = 3'h3;
    localparam mst_idx_type MST_USB_HOST     = 3'h4;

    localparam slv_idx_type SLV_SRAM   = 3'h0;
    localparam slv_idx_type SLV_ROM    = 3'h1;
    localparam slv_idx_type SLV_REGS   = 3'h2;
    localparam slv_idx_type SLV_EXT    = 3'h3;
    localparam slv_idx_type SLV_PERIPH = 3'h4;

    // Top four address bits pick one of 16 areas of 256 Mbytes
    localparam logic [3:0] REGION_INTERNAL  = 4'h0;
    localparam logic [3:0] REGION_EXT_FIRST = 4'h1;
    localparam logic [3:0] REGION_EXT_LAST  = 4'h8;
    localparam logic [3:0] REGION_PERIPH    = 4'hf;

    // Address bits 27:20 pick a 1 Mbyte window inside the internal area
    localparam logic [7:0] WIN_BOOT = 8'h00;
    localparam logic [7:0] WIN_SRAM = 8'h03;
    localparam logic [7:0] WIN_ROM  = 8'h04;
    localparam logic [7:0] WIN_USB  = 8'h05;
    localparam logic [7:0] WIN_LCD  = 8'h06;

    localparam logic [2:0] EXTERNAL_SELECT_ZERO = 3'h0;

    localparam logic [1:0] ARB_MODE_NONE  = 2'h0;
    localparam logic [1:0] ARB_MODE_LAST  = 2'h1;
    localparam logic [1:0] ARB_MODE_FIXED = 2'h2;

    localparam logic [1:0] ALIAS_RESET    = 2'h0;
    localparam logic       BOOT_SEL_RESET = 1'b0;
    localparam logic [7:0] SLOT_CNT_MAX   = 8'hff;
endpackage

//--- hw/route_if.sv
// Decoded route of one master's address, from its decoder to the matrix
interface route_if;
    logic                        hit;
    bus_matrix_pkg::slv_idx_type slave;
    logic [2:0]                  cs;

    modport decoder (output hit, output slave, output cs);
    modport matrix  (input hit, input slave, input cs);
endinterface

//--- hw/master_decoder.sv
// Per-master address decoder with boot window aliasing
module master_decoder #(
    parameter bit HAS_REMAP = 1'b0
) (
    input  wire logic [bus_matrix_pkg::ADDR_W-1:0] i_addr,
    input  wire logic                              i_remap,
    input  wire logic                              i_boot_sel,
    route_if.decoder                               rt
);
    import bus_matrix_pkg::*;

    logic [3:0] region;
    logic [7:0] window;

    assign region = i_addr[31:28];
    assign window = i_addr[27:20];

    always_comb begin
        rt.hit   = 1'b0;
        rt.slave = SLV_SRAM;
        rt.cs    = EXTERNAL_SELECT_ZERO;
        if (region == REGION_INTERNAL) begin
            rt.hit = 1'b1;
            case (window)
                WIN_BOOT: begin
                    if (HAS_REMAP && i_remap) begin
                        rt.slave = SLV_SRAM;
                    end else if (i_boot_sel) begin
                        rt.slave = SLV_ROM;
                    end else begin
                        rt.slave = SLV_EXT;
                    end
                end
                // Fixed windows ignore both remap and boot select
                WIN_SRAM: rt.slave = SLV_SRAM;
                WIN_ROM:  rt.slave = SLV_ROM;
                WIN_USB:  rt.slave = SLV_REGS;
                WIN_LCD:  rt.slave = SLV_REGS;
                default:  rt.hit   = 1'b0;
            endcase
        end else if (region >= REGION_EXT_FIRST && region <= REGION_EXT_LAST) begin
            rt.hit   = 1'b1;
            rt.slave = SLV_EXT;
            rt.cs    = 3'(region - REGION_EXT_FIRST);
        end else if (region == REGION_PERIPH) begin
            rt.hit   = 1'b1;
            rt.slave = SLV_PERIPH;
        end
    end
endmodule

//--- hw/slave_arbiter.sv
// Round-robin arbiter for one slave, with default master and burst breaking
module slave_arbiter #(
    parameter int NM = 5
) (
    input  wire logic                        i_mclk,
    input  wire logic                        i_rst_b,
    input  wire logic [NM-1:0]               i_req,
    input  wire logic [1:0]                  i_mode,
    input  wire bus_matrix_pkg::mst_idx_type i_fixed,
    input  wire logic [7:0]                  i_slot_limit,
    output logic                             o_own_valid,
    output bus_matrix_pkg::mst_idx_type      o_owner
);
    import bus_matrix_pkg::*;

    // Owner index is three bits wide, so eight masters at most
    if (NM < 2 || NM > 8) begin : g_bad_nm
        $error("slave_arbiter: NM must be 2..8");
    end

    logic        own_q;
    mst_idx_type owner_q;
    logic [7:0]  count_q;
    logic        cand_valid;
    mst_idx_type cand;
    logic        others;
    logic        hold;

    always_comb begin
        int idx;
        idx        = 0;
        cand_valid = 1'b0;
        cand       = owner_q;
        // Search starts after the present owner, which is tried last
        for (int k = 1; k <= NM; k++) begin
            idx = (int'(owner_q) + k) % NM;
            if (!cand_valid && i_req[idx]) begin
                cand_valid = 1'b1;
                cand       = mst_idx_type'(idx);
            end
        end
    end

    assign others = |(i_req & ~(NM'(1) << owner_q));
    // Zero limit means bursts are never broken
    assign hold = own_q && i_req[owner_q] &&
                  !(i_slot_limit != 8'h00 && count_q >= i_slot_limit && others);

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            own_q   <= 1'b0;
            owner_q <= MST_INSTR;
        end else if (hold) begin
            own_q <= 1'b1;
        end else if (cand_valid) begin
            own_q   <= 1'b1;
            owner_q <= cand;
        end else begin
            case (i_mode)
                ARB_MODE_LAST:  own_q <= own_q;
                ARB_MODE_FIXED: begin
                    own_q   <= 1'b1;
                    owner_q <= i_fixed;
                end
                default:        own_q <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            count_q <= 8'h00;
        end else if (hold) begin
            count_q <= (count_q == SLOT_CNT_MAX) ? count_q : count_q + 8'h01;
        end else if (cand_valid) begin
            count_q <= 8'h01;
        end else begin
            // Parked owner resumes at one, like a fresh winner
            count_q <= 8'h01;
        end
    end

    assign o_own_valid = own_q;
    assign o_owner     = owner_q;

    a_slot_break: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        own_q && i_req[owner_q] && others && i_slot_limit != 8'h00 && count_q >= i_slot_limit
        |=> owner_q != $past(owner_q))
        else $error("burst not broken at slot limit");
endmodule

//--- hw/bus_matrix_decode_remap.sv
// Five by five bus matrix: per-master decoders, per-slave arbiters, boot remap
// Operation
// - Top four address bits split the 4 GB space into 16 areas.
// - Areas 1 to 8 go to the external bus, area n on select n-1.
// - Area 0 holds internal memories, decoded again into 1 Mbyte windows.
// - Area 15 goes to the internal peripherals bridge.
// - Accesses to unused areas get an error and reach no slave.
// - Five masters are joined to five slaves in a fixed numbering.
// - Every master has its own decoder, so its map may differ.
// - Every slave has its own arbiter with its own settings.
// - Round-robin per slave; idle default master none, last or fixed.
// - A granted burst is broken after a set number of slot cycles.
// - Remap clear and boot select high: ROM appears at address zero.
// - Remap clear and boot select low: external select zero at zero.
// - Instruction and data masters each have a remap bit, set by software, that puts SRAM at address zero.
// - The boot window spans 0x0 to 0x000f_ffff.
// - The ROM always answers at 0x0040_0000 as well.
// - The USB host registers decode at 0x0050_0000.
// - The display registers decode at 0x0060_0000.
// - Fixed windows stay reachable whatever remap and boot select say.
module bus_matrix_decode_remap (
    input  wire logic                                          i_mclk,
    input  wire logic                                          i_rst_b,
    input  wire logic                                          i_boot_select_pin,
    input  wire logic                                          i_alias_bit_master0,
    input  wire logic                                          i_alias_bit_master1,
    input  wire logic [bus_matrix_pkg::NUM_MST-1:0]            i_mst_req,
    input  wire logic [bus_matrix_pkg::NUM_MST-1:0][31:0]      i_mst_addr,
    input  wire logic [bus_matrix_pkg::NUM_SLV-1:0][1:0]       i_arb_mode,
    input  wire bus_matrix_pkg::mst_idx_type [bus_matrix_pkg::NUM_SLV-1:0] i_arb_fixed,
    input  wire logic [bus_matrix_pkg::NUM_SLV-1:0][7:0]       i_slot_limit,
    output logic [bus_matrix_pkg::NUM_MST-1:0]                 o_mst_grant,
    output logic [bus_matrix_pkg::NUM_MST-1:0]                 o_mst_error,
    output logic [bus_matrix_pkg::NUM_SLV-1:0]                 o_slv_valid,
    output bus_matrix_pkg::mst_idx_type [bus_matrix_pkg::NUM_SLV-1:0] o_slv_master,
    output logic [bus_matrix_pkg::NUM_SLV-1:0][31:0]           o_slv_addr,
    output logic [bus_matrix_pkg::EXT_CS_W-1:0]                o_ext_chip_select,
    output logic                                               o_boot_from_rom
);
    import bus_matrix_pkg::*;

    logic [1:0]                          alias_q;
    logic                                boot_sel_q;
    logic                                boot_taken_q;
    logic [NUM_MST-1:0]                  mst_hit;
    slv_idx_type [NUM_MST-1:0]           mst_slave;
    logic [NUM_MST-1:0][2:0]             mst_cs;
    logic [NUM_SLV-1:0][NUM_MST-1:0]     slv_req;
    logic [NUM_SLV-1:0]                  own_valid;
    mst_idx_type [NUM_SLV-1:0]           owner;
    logic [NUM_MST-1:0]                  grant_d;
    logic [NUM_MST-1:0]                  error_d;
    logic [NUM_SLV-1:0]                  slv_valid_d;
    logic [NUM_SLV-1:0][31:0]            slv_addr_d;
    logic [EXT_CS_W-1:0]                 ext_cs_d;

    // Boot select is caught once, at the first edge after reset release
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            boot_sel_q   <= BOOT_SEL_RESET;
            boot_taken_q <= 1'b0;
        end else if (!boot_taken_q) begin
            boot_sel_q   <= i_boot_select_pin;
            boot_taken_q <= 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            alias_q <= ALIAS_RESET;
        end else begin
            alias_q <= {i_alias_bit_master1, i_alias_bit_master0};
        end
    end

    route_if rt [NUM_MST] ();

    // Only the instruction and data masters honour a remap bit
    for (genvar m = 0; m < NUM_MST; m++) begin : g_dec
        master_decoder #(
            .HAS_REMAP (m < 2)
        ) u_dec (
            .i_addr     (i_mst_addr[m]),
            .i_remap    ((m < 2) ? alias_q[m % 2] : 1'b0),
            .i_boot_sel (boot_sel_q),
            .rt         (rt[m])
        );

        assign mst_hit[m]   = rt[m].hit;
        assign mst_slave[m] = rt[m].slave;
        assign mst_cs[m]    = rt[m].cs;

        // Requests are held off until boot select has been caught
        for (genvar s = 0; s < NUM_SLV; s++) begin : g_req
            assign slv_req[s][m] = i_mst_req[m] && boot_taken_q && rt[m].hit &&
                                   (rt[m].slave == slv_idx_type'(s));
        end
    end

    for (genvar s = 0; s < NUM_SLV; s++) begin : g_arb
        slave_arbiter #(
            .NM (NUM_MST)
        ) u_arb (
            .i_mclk       (i_mclk),
            .i_rst_b      (i_rst_b),
            .i_req        (slv_req[s]),
            .i_mode       (i_arb_mode[s]),
            .i_fixed      (i_arb_fixed[s]),
            .i_slot_limit (i_slot_limit[s]),
            .o_own_valid  (own_valid[s]),
            .o_owner      (owner[s])
        );
    end

    always_comb begin
        grant_d     = '0;
        slv_valid_d = '0;
        for (int s = 0; s < NUM_SLV; s++) begin
            slv_addr_d[s] = i_mst_addr[owner[s]];
            for (int m = 0; m < NUM_MST; m++) begin
                if (slv_req[s][m] && own_valid[s] && owner[s] == mst_idx_type'(m)) begin
                    grant_d[m]     = 1'b1;
                    slv_valid_d[s] = 1'b1;
                end
            end
        end
    end

    // Unused areas abort locally; no slave ever sees them
    always_comb begin
        error_d = '0;
        for (int m = 0; m < NUM_MST; m++) begin
            error_d[m] = i_mst_req[m] && boot_taken_q && !mst_hit[m];
        end
    end

    always_comb begin
        ext_cs_d = '0;
        if (slv_valid_d[SLV_EXT]) begin
            ext_cs_d = EXT_CS_W'(1) << mst_cs[owner[SLV_EXT]];
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_mst_grant <= '0;
            o_mst_error <= '0;
        end else begin
            o_mst_grant <= grant_d;
            o_mst_error <= error_d;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_slv_valid       <= '0;
            o_slv_master      <= '0;
            o_slv_addr        <= '0;
            o_ext_chip_select <= '0;
        end else begin
            o_slv_valid       <= slv_valid_d;
            o_slv_master      <= owner;
            o_slv_addr        <= slv_addr_d;
            o_ext_chip_select <= ext_cs_d;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_boot_from_rom <= 1'b0;
        end else begin
            o_boot_from_rom <= boot_sel_q;
        end
    end

    a_region_ext: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_mst_addr[1][31:28] >= REGION_EXT_FIRST && i_mst_addr[1][31:28] <= REGION_EXT_LAST)
        |-> (mst_hit[1] && mst_slave[1] == SLV_EXT &&
             mst_cs[1] == 3'(i_mst_addr[1][31:28] - REGION_EXT_FIRST)))
        else $error("external area decoded to wrong select");

    a_region_periph: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        i_mst_addr[2][31:28] == REGION_PERIPH |-> mst_hit[2] && mst_slave[2] == SLV_PERIPH)
        else $error("peripheral area not routed to bridge");

    a_unused_abort: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        i_mst_req[0] && boot_taken_q && i_mst_addr[0][31:28] > REGION_EXT_LAST &&
        i_mst_addr[0][31:28] < REGION_PERIPH
        |=> o_mst_error[0] && !o_mst_grant[0])
        else $error("unused area did not abort");

    a_rom_fixed: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        i_mst_addr[0][31:20] == {REGION_INTERNAL, WIN_ROM} |-> mst_slave[0] == SLV_ROM)
        else $error("ROM base not decoded");

    a_regs_fixed: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        i_mst_addr[3][31:20] == {REGION_INTERNAL, WIN_USB} ||
        i_mst_addr[3][31:20] == {REGION_INTERNAL, WIN_LCD}
        |-> mst_hit[3] && mst_slave[3] == SLV_REGS)
        else $error("register port window not decoded");

    a_remap_sram: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        alias_q[1] && i_mst_addr[1][31:20] == 12'h000 |-> mst_slave[1] == SLV_SRAM)
        else $error("remapped boot window not on SRAM");

    a_boot_rom: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        !alias_q[0] && boot_sel_q && i_mst_addr[0][31:20] == 12'h000
        |-> mst_slave[0] == SLV_ROM)
        else $error("boot window not on ROM");

    a_boot_ext: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        !alias_q[1] && !boot_sel_q && i_mst_addr[1][31:20] == 12'h000
        |-> mst_slave[1] == SLV_EXT && mst_cs[1] == EXTERNAL_SELECT_ZERO)
        else $error("boot window not on external select zero");

    a_grant_cause: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        o_mst_grant[1] |-> $past(i_mst_req[1]) && $past(mst_hit[1]))
        else $error("grant without a decoded request");

    a_ext_onehot: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        o_slv_valid[SLV_EXT] ? $onehot(o_ext_chip_select) : (o_ext_chip_select == '0))
        else $error("external chip select not one-hot");

    a_remap_instr: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        alias_q[0] && i_mst_addr[0][31:20] == 12'h000 |-> mst_slave[0] == SLV_SRAM)
        else $error("instruction master remap not on SRAM");

    a_dma_boot: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        i_mst_addr[2][31:20] == 12'h000
        |-> mst_hit[2] && mst_slave[2] == (boot_sel_q ? SLV_ROM : SLV_EXT))
        else $error("DMA master boot window wrong");

    a_sram_fixed: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        i_mst_addr[4][31:20] == {REGION_INTERNAL, WIN_SRAM}
        |-> mst_hit[4] && mst_slave[4] == SLV_SRAM)
        else $error("fixed SRAM window not decoded");

    a_grant_pairs: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        $countones(o_mst_grant) == $countones(o_slv_valid))
        else $error("grants and slave valids do not pair");
endmodule

//--- sim/master_model.sv
// Behavioural bus masters that hold each request until it is answered
module master_model (
    input  wire logic                                     i_mclk,
    input  wire logic                                     i_rst_b,
    input  wire logic [bus_matrix_pkg::NUM_MST-1:0]       i_start,
    input  wire logic [bus_matrix_pkg::NUM_MST-1:0][31:0] i_addr,
    input  wire logic [7:0]                               i_beats,
    input  wire logic [bus_matrix_pkg::NUM_MST-1:0]       i_grant,
    input  wire logic [bus_matrix_pkg::NUM_MST-1:0]       i_error,
    output logic      [bus_matrix_pkg::NUM_MST-1:0]       o_req,
    output logic      [bus_matrix_pkg::NUM_MST-1:0][31:0] o_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    import bus_matrix_pkg::*;

    logic [NUM_MST-1:0][7:0] left_q;

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_req  <= '0;
            o_addr <= '0;
            left_q <= '0;
        end else begin
            for (int m = 0; m < NUM_MST; m++) begin
                if (i_start[m]) begin
                    o_req[m]  <= 1'b1;
                    o_addr[m] <= i_addr[m];
                    left_q[m] <= i_beats;
                end else if (o_req[m] && (i_grant[m] || i_error[m])) begin
                    // Answer lags a cycle, so one beat more than asked goes out
                    left_q[m] <= left_q[m] - 8'h01;
                    if (left_q[m] == 8'h01) begin
                        o_req[m]  <= 1'b0;
                        // Released lines must not keep showing the old address
                        o_addr[m] <= ~o_addr[m];
                    end
                end
            end
        end
    end
endmodule

//--- sim/tb_top.sv
// Self-checking bench for the bus matrix decode, remap and arbitration
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import bus_matrix_pkg::*;

    logic                      mclk;
    logic                      rst_b;
    logic                      boot_pin;
    logic [1:0]                alias_bits;
    logic [NUM_MST-1:0]        mst_req;
    logic [NUM_MST-1:0][31:0]  mst_addr;
    logic [NUM_SLV-1:0][1:0]   arb_mode;
    mst_idx_type [NUM_SLV-1:0] arb_fixed;
    logic [NUM_SLV-1:0][7:0]   slot_limit;
    logic [NUM_MST-1:0]        grant;
    logic [NUM_MST-1:0]        err;
    logic [NUM_SLV-1:0]        slv_valid;
    mst_idx_type [NUM_SLV-1:0] slv_master;
    logic [NUM_SLV-1:0][31:0]  slv_addr;
    logic [EXT_CS_W-1:0]       ext_cs;
    logic                      boot_rom;
    logic [NUM_MST-1:0]        start;
    logic [NUM_MST-1:0][31:0]  start_addr;
    logic [7:0]                beats;
    logic [31:0]               seed;
    int                        failures;
    int                        check_count;
    int                        cycles;
    logic [31:0]               corner [11] = '{32'h0000_0000, 32'h000f_fffc, 32'h0010_0000,
        32'h0030_0040, 32'h0040_0000, 32'h0050_0010, 32'h0060_0020, 32'h1000_0000,
        32'h8fff_fff0, 32'h9000_0000, 32'hf000_0100};

    bus_matrix_decode_remap u_bus_matrix_decode_remap (
        .i_mclk              (mclk),
        .i_rst_b             (rst_b),
        .i_boot_select_pin   (boot_pin),
        .i_alias_bit_master0 (alias_bits[0]),
        .i_alias_bit_master1 (alias_bits[1]),
        .i_mst_req           (mst_req),
        .i_mst_addr          (mst_addr),
        .i_arb_mode          (arb_mode),
        .i_arb_fixed         (arb_fixed),
        .i_slot_limit        (slot_limit),
        .o_mst_grant         (grant),
        .o_mst_error         (err),
        .o_slv_valid         (slv_valid),
        .o_slv_master        (slv_master),
        .o_slv_addr          (slv_addr),
        .o_ext_chip_select   (ext_cs),
        .o_boot_from_rom     (boot_rom)
    );

    master_model u_master_model (
        .i_mclk  (mclk),
        .i_rst_b (rst_b),
        .i_start (start),
        .i_addr  (start_addr),
        .i_beats (beats),
        .i_grant (grant),
        .i_error (err),
        .o_req   (mst_req),
        .o_addr  (mst_addr)
    );

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Expected route as {abort, slave, select}
    function automatic logic [6:0] exp_route(input int m, input logic [31:0] a,
                                             input logic remap, input logic boot);
        logic [3:0] area;
        area = a[31:28];
        if (area >= 4'h1 && area <= 4'h8) return {1'b0, SLV_EXT, 3'(area - 4'h1)};
        if (area == 4'hf) return {1'b0, SLV_PERIPH, 3'h0};
        if (area != 4'h0) return {1'b1, 6'h00};
        case (a[27:20])
            8'h00: begin
                if (m < 2 && remap) return {1'b0, SLV_SRAM, 3'h0};
                return boot ? {1'b0, SLV_ROM, 3'h0} : {1'b0, SLV_EXT, 3'h0};
            end
            8'h03: return {1'b0, SLV_SRAM, 3'h0};
            8'h04: return {1'b0, SLV_ROM, 3'h0};
            8'h05, 8'h06: return {1'b0, SLV_REGS, 3'h0};
            default: return {1'b1, 6'h00};
        endcase
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d, failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic do_reset(input logic pin);
        @(posedge mclk);
        rst_b    <= 1'b0;
        boot_pin <= pin;
        repeat (12) @(posedge mclk);
        chk("outputs in reset", 32'h0, {grant, err, slv_valid, ext_cs});
        rst_b <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        chk("boot from rom", pin, boot_rom);
    endtask

    // One uncontended access; looks at the first answering cycle
    task automatic access(input int m, input logic [31:0] a);
        logic [6:0] e;
        int         n;
        e = exp_route(m, a, (m < 2) ? alias_bits[m % 2] : 1'b0, boot_pin);
        n = 0;
        @(posedge mclk);
        start[m]      <= 1'b1;
        start_addr[m] <= a;
        @(posedge mclk);
        start <= '0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (grant[m] !== 1'b1 && err[m] !== 1'b1 && n < 20);
        chk("abort", e[6], err[m]);
        chk("grant", !e[6], grant[m]);
        chk("slave valid", e[6] ? 32'h0 : 32'h1 << e[5:3], slv_valid);
        if (!e[6]) begin
            chk("owner", m, slv_master[e[5:3]]);
            chk("slave address", a, slv_addr[e[5:3]]);
        end
        chk("select", (!e[6] && e[5:3] == SLV_EXT) ? 32'h1 << e[2:0] : 32'h0, ext_cs);
        repeat (3) @(posedge mclk);
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end

    initial begin
        logic [31:0] addr;
        int          run;
        int          best;
        int          n2;
        int          n3;
        rst_b = 1'b0;
        boot_pin = 1'b0;
        alias_bits = 2'h0;
        start = '0;
        start_addr = '0;
        beats = 8'h01;
        arb_mode = {2'h0, 2'h0, 2'h0, ARB_MODE_LAST, ARB_MODE_FIXED};
        arb_fixed = {NUM_SLV{MST_USB_HOST}};
        slot_limit = {8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
        seed = 32'hcf506a14;
        for (int b = 1; b >= 0; b--) begin
            do_reset(b[0]);
            for (int r = 0; r < 4; r++) begin
                @(posedge mclk);
                alias_bits <= r[1:0];
                repeat (2) @(posedge mclk);
                for (int i = 0; i < 11; i++) begin
                    for (int m = 0; m < 3; m++) begin
                        access(m, corner[i]);
                    end
                end
                for (int i = 0; i < 20; i++) begin
                    seed = lfsr(seed);
                    addr = seed;
                    // Keep most internal-area picks inside the mapped windows
                    if (seed[31:28] == 4'h0) addr[27:23] = 5'h00;
                    access(seed[10:8] % 5, addr);
                end
            end
        end
        // Two masters fight over SRAM; the slot limit must force sharing
        @(posedge mclk);
        beats         <= 8'h10;
        start         <= 5'h0c;
        start_addr[2] <= 32'h0030_0010;
        start_addr[3] <= 32'h0030_0020;
        @(posedge mclk);
        start <= '0;
        run = 0;
        best = 0;
        n2 = 0;
        n3 = 0;
        repeat (30) begin
            @(posedge mclk);
            #1;
            chk("single owner", 32'h0, grant[2] & grant[3]);
            run = (grant[2] === 1'b1) ? run + 1 : 0;
            best = (run > best) ? run : best;
            n2 += (grant[2] === 1'b1);
            n3 += (grant[3] === 1'b1);
        end
        chk("burst length", 32'(slot_limit[0]), best);
        chk("both served", 32'h1, n2 > 0 && n3 > 0);
        repeat (60) @(posedge mclk);
        #1;
        chk("fixed park", {1'b0, MST_USB_HOST}, {slv_valid[0], slv_master[0]});
        beats <= 8'h01;
        access(3, 32'h0040_0000);
        #1;
        chk("last park", {1'b0, MST_DISPLAY}, {slv_valid[1], slv_master[1]});
        conclude();
    end
endmodule
